//--- hw/ble_pkg.sv
// Purpose: Shared constants and types for the branch, logic and shift executor
// Assumes: 8-bit data path, 15-bit program counter, 7-bit file addresses
// Notes:   Datapath widths, latch and MSB bit positions, and counter, accumulator and flag reset values live here
package ble_pkg;

    localparam int          BLE_PC_W       = 15;
    localparam int          BLE_LIT_W      = 11;
    localparam int          BLE_FADDR_W    = 7;
    localparam int          BLE_DATA_W     = 8;
    localparam int          BLE_LATCH_W    = 7;
    localparam int          BLE_LATCH_HI   = 6;
    localparam int          BLE_LATCH_LO   = 3;
    localparam int          BLE_JUMP_CYC   = 2;
    localparam int          BLE_DATA_MSB   = 7;
    localparam logic [14:0] BLE_PC_RESET   = 15'h0000;
    localparam logic [14:0] BLE_PC_STEP    = 15'h0001;
    localparam logic [7:0]  BLE_ACC_RESET  = 8'h00;
    localparam logic [7:0]  BLE_DATA_ONE   = 8'h01;
    localparam logic [7:0]  BLE_DATA_ZERO  = 8'h00;
    localparam logic        BLE_FLAG_RESET = 1'b0;
    localparam logic        BLE_DEST_ACC   = 1'b0;
    localparam logic        BLE_DEST_FILE  = 1'b1;

    // Operations carried out by the executor
    typedef enum logic [2:0] {
        BLE_OP_JUMP_ABSOLUTE,
        BLE_OP_OR_LITERAL_INTO_ACC,
        BLE_OP_ADD_ONE_TO_FILE,
        BLE_OP_OR_ACC_WITH_FILE,
        BLE_OP_SHIFT_LEFT_LOGICAL,
        BLE_OP_SHIFT_RIGHT_LOGICAL
    } ble_op_t;

    // One decoded instruction with its file operand already read
    typedef struct packed {
        ble_op_t          op;
        logic [10:0]      lit;
        logic [6:0]       faddr;
        logic             dest;
        logic [7:0]       fdata;
    } ble_req_t;

    // Write-back to the file registers
    typedef struct packed {
        logic             we;
        logic [6:0]       addr;
        logic [7:0]       data;
    } ble_fwr_t;

endpackage

//--- hw/ble_exec.sv
// Purpose: Executes absolute jump, OR, increment and logical shift instructions
// Assumes: Decoder presents one instruction per cycle with its file operand read
// Notes:   Owns accumulator, zero flag, shift-out flag and program counter
`timescale 1ns/1ps

// Functional notes
// RULE1 - Jump loads literal into counter bits 10:0
// RULE2 - Jump loads latch bits 6:3 into 14:11
// RULE3 - Jump takes two cycles, flags untouched
// RULE4 - OR literal into accumulator, update zero
// RULE5 - Increment file operand, update zero flag
// RULE6 - Destination bit: 0 accumulator, 1 file
// RULE7 - OR accumulator with file, update zero
// RULE8 - Left shift: bit7 out, zero in
// RULE9 - Shifts update shift-out, zero, honour destination
// RULE10 - Right shift: zero in, bit0 out
// RULE11 - Zero flag set exactly when result zero
module ble_exec
    import ble_pkg::*;
(
    input  wire logic                  CLK,
    input  wire logic                  RESET,
    input  wire ble_req_t              REQ,
    input  wire logic                  REQ_VALID,
    output logic                       REQ_READY,
    input  wire logic [BLE_LATCH_W-1:0] LATCH,
    output logic [BLE_PC_W-1:0]        PC,
    output logic [BLE_DATA_W-1:0]      ACC,
    output logic                       ZERO_FLAG,
    output logic                       SHIFT_OUT,
    output ble_fwr_t                   FILE_WR
);

    typedef enum logic [0:0] {
        ST_RUN,
        ST_JUMP_FILL
    } ble_state_t;

    ble_state_t                 state;
    ble_state_t                 next_state;
    logic [BLE_PC_W-1:0]        pc;
    logic [BLE_PC_W-1:0]        next_pc;
    logic [BLE_DATA_W-1:0]      acc;
    logic [BLE_DATA_W-1:0]      next_acc;
    logic                       zero;
    logic                       next_zero;
    logic                       carry;
    logic                       next_carry;
    ble_fwr_t                   fwr;
    ble_fwr_t                   next_fwr;
    logic [BLE_DATA_W-1:0]      result;
    logic                       writes_result;
    logic                       to_file;
    logic                       take;

    assign REQ_READY = (state == ST_RUN);
    assign take      = REQ_VALID && REQ_READY;

    // Next-value logic for the whole execution state
    always_comb begin
        next_state    = state;
        next_pc       = pc;
        next_acc      = acc;
        next_zero     = zero;
        next_carry    = carry;
        next_fwr      = '0;
        result        = BLE_DATA_ZERO;
        writes_result = 1'b0;
        to_file       = 1'b0;
        if (state == ST_JUMP_FILL) begin
            // Second jump cycle: fetch slot is discarded
            next_state = ST_RUN; // RULE3
        end else if (REQ_VALID) begin
            next_pc = pc + BLE_PC_STEP;
            unique case (REQ.op)
                BLE_OP_JUMP_ABSOLUTE: begin
                    next_pc[BLE_LIT_W-1:0]        = REQ.lit; // RULE1
                    next_pc[BLE_PC_W-1:BLE_LIT_W] =
                        LATCH[BLE_LATCH_HI:BLE_LATCH_LO]; // RULE2
                    next_state                    = ST_JUMP_FILL; // RULE3
                end
                BLE_OP_OR_LITERAL_INTO_ACC: begin
                    result        = acc | REQ.lit[BLE_DATA_W-1:0]; // RULE4
                    writes_result = 1'b1;
                end
                BLE_OP_ADD_ONE_TO_FILE: begin
                    result        = REQ.fdata + BLE_DATA_ONE; // RULE5
                    writes_result = 1'b1;
                    to_file       = REQ.dest;
                end
                BLE_OP_OR_ACC_WITH_FILE: begin
                    result        = acc | REQ.fdata; // RULE7
                    writes_result = 1'b1;
                    to_file       = REQ.dest;
                end
                BLE_OP_SHIFT_LEFT_LOGICAL: begin
                    result        = {REQ.fdata[BLE_DATA_MSB-1:0], 1'b0}; // RULE8
                    next_carry    = REQ.fdata[BLE_DATA_MSB]; // RULE8 RULE9
                    writes_result = 1'b1;
                    to_file       = REQ.dest;
                end
                BLE_OP_SHIFT_RIGHT_LOGICAL: begin
                    result        = {1'b0, REQ.fdata[BLE_DATA_MSB:1]}; // RULE10
                    next_carry    = REQ.fdata[0]; // RULE10 RULE9
                    writes_result = 1'b1;
                    to_file       = REQ.dest;
                end
                default: begin
                    // Illegal operation code: counter still advances
                    writes_result = 1'b0;
                end
            endcase
            if (writes_result) begin
                next_zero = (result == BLE_DATA_ZERO); // RULE11
                if (to_file == BLE_DEST_FILE) begin
                    next_fwr.we   = 1'b1; // RULE6
                    next_fwr.addr = REQ.faddr;
                    next_fwr.data = result;
                end else begin
                    next_acc = result; // RULE6
                end
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            state <= ST_RUN;
            pc    <= BLE_PC_RESET;
            acc   <= BLE_ACC_RESET;
            zero  <= BLE_FLAG_RESET;
            carry <= BLE_FLAG_RESET;
            fwr   <= '0;
        end else begin
            state <= next_state;
            pc    <= next_pc;
            acc   <= next_acc;
            zero  <= next_zero;
            carry <= next_carry;
            fwr   <= next_fwr;
        end
    end

    assign PC        = pc;
    assign ACC       = acc;
    assign ZERO_FLAG = zero;
    assign SHIFT_OUT = carry;
    assign FILE_WR   = fwr;

    default clocking ble_cb @(posedge CLK);
    endclocking
    default disable iff (RESET);

    jump_low_a: assert property ( // RULE1
        take && REQ.op == BLE_OP_JUMP_ABSOLUTE
        |=> PC[BLE_LIT_W-1:0] == $past(REQ.lit)
    ) else $error("jump literal not loaded into low counter bits");

    jump_high_a: assert property ( // RULE2
        take && REQ.op == BLE_OP_JUMP_ABSOLUTE
        |=> PC[BLE_PC_W-1:BLE_LIT_W] == $past(LATCH[BLE_LATCH_HI:BLE_LATCH_LO])
    ) else $error("jump high counter bits not taken from latch");

    jump_stall_a: assert property ( // RULE3
        take && REQ.op == BLE_OP_JUMP_ABSOLUTE
        |=> !REQ_READY ##1 REQ_READY
    ) else $error("jump did not take exactly two cycles");

    jump_flags_a: assert property ( // RULE3
        take && REQ.op == BLE_OP_JUMP_ABSOLUTE
        |=> $stable(ZERO_FLAG) && $stable(SHIFT_OUT) && $stable(ACC)
            && !FILE_WR.we
    ) else $error("jump changed flags or data");

    or_literal_a: assert property ( // RULE4
        take && REQ.op == BLE_OP_OR_LITERAL_INTO_ACC
        |=> ACC == ($past(ACC) | $past(REQ.lit[BLE_DATA_W-1:0])) && !FILE_WR.we
    ) else $error("literal OR result wrong");

    incr_file_a: assert property ( // RULE5
        take && REQ.op == BLE_OP_ADD_ONE_TO_FILE && REQ.dest == BLE_DEST_FILE
        |=> FILE_WR.we && FILE_WR.addr == $past(REQ.faddr)
            && FILE_WR.data == 8'($past(REQ.fdata) + BLE_DATA_ONE)
    ) else $error("increment write-back wrong");

    dest_acc_a: assert property ( // RULE6
        take && REQ.op != BLE_OP_JUMP_ABSOLUTE && REQ.dest == BLE_DEST_ACC
        |=> !FILE_WR.we
    ) else $error("file written with accumulator destination");

    or_file_a: assert property ( // RULE7
        take && REQ.op == BLE_OP_OR_ACC_WITH_FILE && REQ.dest == BLE_DEST_ACC
        |=> ACC == ($past(ACC) | $past(REQ.fdata))
    ) else $error("file OR result wrong");

    shl_data_a: assert property ( // RULE8
        take && REQ.op == BLE_OP_SHIFT_LEFT_LOGICAL && REQ.dest == BLE_DEST_ACC
        |=> ACC == {$past(REQ.fdata[BLE_DATA_MSB-1:0]), 1'b0}
            && SHIFT_OUT == $past(REQ.fdata[BLE_DATA_MSB])
    ) else $error("left shift result or shift-out wrong");

    shift_file_a: assert property ( // RULE9
        take && (REQ.op == BLE_OP_SHIFT_LEFT_LOGICAL
                 || REQ.op == BLE_OP_SHIFT_RIGHT_LOGICAL)
             && REQ.dest == BLE_DEST_FILE
        |=> FILE_WR.we && $stable(ACC) && ZERO_FLAG == (FILE_WR.data == BLE_DATA_ZERO)
    ) else $error("shift to file did not honour destination");

    shr_data_a: assert property ( // RULE10
        take && REQ.op == BLE_OP_SHIFT_RIGHT_LOGICAL && REQ.dest == BLE_DEST_ACC
        |=> ACC == {1'b0, $past(REQ.fdata[BLE_DATA_MSB:1])}
            && SHIFT_OUT == $past(REQ.fdata[0])
    ) else $error("right shift result or shift-out wrong");

    zero_flag_a: assert property ( // RULE11
        take && REQ.op inside {BLE_OP_OR_LITERAL_INTO_ACC, BLE_OP_ADD_ONE_TO_FILE,
                               BLE_OP_OR_ACC_WITH_FILE}
        |=> ZERO_FLAG == (FILE_WR.we ? (FILE_WR.data == BLE_DATA_ZERO)
                                     : (ACC == BLE_DATA_ZERO))
    ) else $error("zero flag does not match result");

    // Checks below cover the destination, hold and illegal-code paths

    jump_target_a: assert property ( // RULE2
        take && REQ.op == BLE_OP_JUMP_ABSOLUTE
        |=> PC == {$past(LATCH[BLE_LATCH_HI:BLE_LATCH_LO]), $past(REQ.lit)}
    ) else $error("jump target not assembled from latch and literal");

    dead_cycle_a: assert property ( // RULE3
        !REQ_READY
        |=> $stable(PC) && $stable(ACC) && $stable(ZERO_FLAG) && !FILE_WR.we
    ) else $error("request acted on during jump dead cycle");

    no_take_a: assert property ( // RULE3
        REQ_READY && !REQ_VALID
        |=> $stable(PC) && $stable(ACC) && $stable(SHIFT_OUT) && !FILE_WR.we
    ) else $error("state changed with no instruction taken");

    pc_step_a: assert property ( // RULE3
        take && REQ.op != BLE_OP_JUMP_ABSOLUTE
        |=> PC == $past(PC) + BLE_PC_STEP && REQ_READY
    ) else $error("counter did not advance by one");

    incr_acc_a: assert property ( // RULE5
        take && REQ.op == BLE_OP_ADD_ONE_TO_FILE && REQ.dest == BLE_DEST_ACC
        |=> ACC == 8'($past(REQ.fdata) + BLE_DATA_ONE) && !FILE_WR.we
    ) else $error("increment into accumulator wrong");

    carry_keep_a: assert property ( // RULE5
        take && REQ.op inside {BLE_OP_OR_LITERAL_INTO_ACC, BLE_OP_ADD_ONE_TO_FILE,
                               BLE_OP_OR_ACC_WITH_FILE}
        |=> $stable(SHIFT_OUT)
    ) else $error("shift-out changed by non-shift instruction");

    file_keeps_acc_a: assert property ( // RULE6
        take && REQ.op inside {BLE_OP_ADD_ONE_TO_FILE, BLE_OP_OR_ACC_WITH_FILE}
             && REQ.dest == BLE_DEST_FILE
        |=> $stable(ACC) && FILE_WR.we && FILE_WR.addr == $past(REQ.faddr)
    ) else $error("file destination disturbed the accumulator");

    we_pulse_a: assert property ( // RULE6
        !take
        |=> !FILE_WR.we
    ) else $error("file write without a taken instruction");

    illegal_op_a: assert property ( // RULE6
        take && !(REQ.op inside {BLE_OP_JUMP_ABSOLUTE, BLE_OP_OR_LITERAL_INTO_ACC,
                                 BLE_OP_ADD_ONE_TO_FILE, BLE_OP_OR_ACC_WITH_FILE,
                                 BLE_OP_SHIFT_LEFT_LOGICAL, BLE_OP_SHIFT_RIGHT_LOGICAL})
        |=> $stable(ACC) && $stable(ZERO_FLAG) && $stable(SHIFT_OUT) && !FILE_WR.we
    ) else $error("illegal operation changed data or flags");

    or_file_wr_a: assert property ( // RULE7
        take && REQ.op == BLE_OP_OR_ACC_WITH_FILE && REQ.dest == BLE_DEST_FILE
        |=> FILE_WR.data == ($past(ACC) | $past(REQ.fdata))
    ) else $error("file OR write-back wrong");

    shl_file_a: assert property ( // RULE8
        take && REQ.op == BLE_OP_SHIFT_LEFT_LOGICAL && REQ.dest == BLE_DEST_FILE
        |=> FILE_WR.data == {$past(REQ.fdata[BLE_DATA_MSB-1:0]), 1'b0}
            && SHIFT_OUT == $past(REQ.fdata[BLE_DATA_MSB])
    ) else $error("left shift write-back wrong");

    shr_file_a: assert property ( // RULE10
        take && REQ.op == BLE_OP_SHIFT_RIGHT_LOGICAL && REQ.dest == BLE_DEST_FILE
        |=> FILE_WR.data == {1'b0, $past(REQ.fdata[BLE_DATA_MSB:1])}
            && SHIFT_OUT == $past(REQ.fdata[0])
    ) else $error("right shift write-back wrong");

    zero_shift_a: assert property ( // RULE11
        take && (REQ.op == BLE_OP_SHIFT_LEFT_LOGICAL
                 || REQ.op == BLE_OP_SHIFT_RIGHT_LOGICAL)
             && REQ.dest == BLE_DEST_ACC
        |=> ZERO_FLAG == (ACC == BLE_DATA_ZERO)
    ) else $error("zero flag wrong after shift");

endmodule

//--- dv/branch_logic_shift_exec_test.sv
// Purpose: Self-checking bench for the branch, logic and shift executor
// Assumes: Inputs change on the falling edge and results are read one falling edge later
// Notes:   run_op predicts every output with a small reference model
`timescale 1ns/1ps
module branch_logic_shift_exec_test;
    import ble_pkg::*;
    logic                   clk = 1'b0;
    logic                   reset = 1'b1;
    ble_req_t               req = '0;
    logic                   req_valid = 1'b0;
    logic                   req_ready;
    logic [BLE_LATCH_W-1:0] latch = '0;
    logic [BLE_PC_W-1:0]    pc;
    logic [BLE_DATA_W-1:0]  acc;
    logic                   zero_flag;
    logic                   shift_out;
    ble_fwr_t               file_wr;
    logic [BLE_PC_W-1:0]    exp_pc;
    logic [BLE_DATA_W-1:0]  exp_acc;
    logic                   exp_z;
    logic                   exp_c;
    int                     error_cnt = 0;
    int                     checks_done = 0;

    always #5 clk = ~clk;

    ble_exec ble_exec_inst (.CLK(clk), .RESET(reset), .REQ(req), .REQ_VALID(req_valid),
        .REQ_READY(req_ready), .LATCH(latch), .PC(pc), .ACC(acc), .ZERO_FLAG(zero_flag),
        .SHIFT_OUT(shift_out), .FILE_WR(file_wr));

    task automatic check(input logic [15:0] seen, input logic [15:0] expv);
        checks_done++;
        if (seen !== expv) begin
            error_cnt++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, expv);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic check_all(input ble_fwr_t ew, input logic er);
        check(16'(pc), 16'(exp_pc));
        check(16'(acc), 16'(exp_acc));
        check(16'(zero_flag), 16'(exp_z));
        check(16'(shift_out), 16'(exp_c));
        check(16'(req_ready), 16'(er));
        if (ew.we) check(file_wr, ew);
        else check(16'(file_wr.we), 16'h0000);
    endtask

    task automatic run_op(input ble_op_t op, input logic [10:0] lit, input logic [6:0] fa,
                          input logic d, input logic [7:0] fd);
        logic [7:0] r;
        ble_fwr_t   ew;
        int         n;
        n = 0;
        while (req_ready !== 1'b1 && n < 4) begin
            @(negedge clk);
            n++;
        end
        if (req_ready !== 1'b1) begin
            error_cnt++;
            stop_test();
        end
        req = '{op: op, lit: lit, faddr: fa, dest: d, fdata: fd};
        req_valid = 1'b1;
        ew = '0;
        r = exp_acc;
        exp_pc = exp_pc + BLE_PC_STEP;
        case (op)
            BLE_OP_JUMP_ABSOLUTE:       exp_pc = {latch[BLE_LATCH_HI:BLE_LATCH_LO], lit};
            BLE_OP_OR_LITERAL_INTO_ACC: r = exp_acc | lit[7:0];
            BLE_OP_ADD_ONE_TO_FILE:     r = fd + BLE_DATA_ONE;
            BLE_OP_OR_ACC_WITH_FILE:    r = exp_acc | fd;
            BLE_OP_SHIFT_LEFT_LOGICAL:  {exp_c, r} = {fd, 1'b0};
            BLE_OP_SHIFT_RIGHT_LOGICAL: {r, exp_c} = {1'b0, fd};
            default:                    r = exp_acc;
        endcase
        if (op > BLE_OP_JUMP_ABSOLUTE && op <= BLE_OP_SHIFT_RIGHT_LOGICAL) begin
            exp_z = (r == BLE_DATA_ZERO);
            if (d == BLE_DEST_FILE && op != BLE_OP_OR_LITERAL_INTO_ACC) ew = '{1'b1, fa, r};
            else exp_acc = r;
        end
        @(negedge clk);
        check_all(ew, op != BLE_OP_JUMP_ABSOLUTE);
    endtask

    task automatic t_reset();
        req_valid = 1'b0;
        reset = 1'b1;
        repeat (2) @(negedge clk);
        reset = 1'b0;
        exp_pc = BLE_PC_RESET;
        exp_acc = BLE_ACC_RESET;
        exp_z = BLE_FLAG_RESET;
        exp_c = BLE_FLAG_RESET;
        check_all('0, 1'b1);
        $display("test reset done");
    endtask

    task automatic t_logic();
        run_op(BLE_OP_OR_LITERAL_INTO_ACC, 11'h000, 7'h00, 1'b1, 8'h00);
        run_op(BLE_OP_OR_LITERAL_INTO_ACC, 11'h7F0, 7'h00, 1'b1, 8'h00);
        run_op(BLE_OP_ADD_ONE_TO_FILE, 11'h000, 7'h05, 1'b1, 8'hFF);
        run_op(BLE_OP_ADD_ONE_TO_FILE, 11'h000, 7'h7F, 1'b0, 8'h41);
        run_op(BLE_OP_OR_ACC_WITH_FILE, 11'h000, 7'h00, 1'b1, 8'h81);
        run_op(BLE_OP_OR_ACC_WITH_FILE, 11'h000, 7'h10, 1'b0, 8'h00);
        $display("test logic done");
    endtask

    task automatic t_shift();
        run_op(BLE_OP_SHIFT_LEFT_LOGICAL, 11'h000, 7'h01, 1'b0, 8'h81);
        run_op(BLE_OP_SHIFT_LEFT_LOGICAL, 11'h000, 7'h02, 1'b1, 8'h80);
        run_op(BLE_OP_SHIFT_RIGHT_LOGICAL, 11'h000, 7'h03, 1'b0, 8'h01);
        run_op(BLE_OP_SHIFT_RIGHT_LOGICAL, 11'h000, 7'h7E, 1'b1, 8'hFE);
        $display("test shift done");
    endtask

    task automatic t_jump(input logic [6:0] lv, input logic [10:0] target);
        latch = lv;
        run_op(BLE_OP_JUMP_ABSOLUTE, target, 7'h00, 1'b0, 8'h00);
        // Request in the dead cycle must be dropped
        req = '{BLE_OP_OR_LITERAL_INTO_ACC, 11'h0FF, 7'h00, 1'b0, 8'h00};
        @(negedge clk);
        check_all('0, 1'b1);
        req_valid = 1'b0;
        @(negedge clk);
        $display("test jump done");
    endtask

    task automatic t_illegal();
        run_op(ble_op_t'(3'h7), 11'h7FF, 7'h7F, 1'b1, 8'hFF);
        $display("test illegal done");
    endtask

    initial begin
        t_reset();
        t_logic();
        t_shift();
        t_jump(7'h28, 11'h123);
        t_jump(7'h47, 11'h7FF);
        t_illegal();
        t_reset();
        t_logic();
        stop_test();
    end
endmodule
